/* File: include/pcc_params.svh */
// Offsets, field positions, reset values and widths of the command bank.
`ifndef PCC_PARAMS_SVH
`define PCC_PARAMS_SVH

// Configuration space byte offset of the command register.
`define PCC_CMD_OFFSET      8'h04
// Width of a configuration address and of a configuration data word.
`define PCC_CFG_ADDR_W      8
`define PCC_CFG_DATA_W      32
// Width of the command register itself.
`define PCC_CMD_W           16
// Bit positions of the low control bits.
`define PCC_BIT_RESERVED0   0
`define PCC_BIT_MEM_SPACE   1
`define PCC_BIT_BUS_MASTER  2
`define PCC_BIT_SPECIAL     3
`define PCC_BIT_WRINV       4
// Reset value of the whole command register.
`define PCC_CMD_RESET       16'h0000
// Value returned for bits and offsets that hold nothing here.
`define PCC_ZERO_WORD       32'h0000_0000

`endif

/* File: include/pcc_pkg.sv */
// Types shared by the command bank and its transaction gate.
package pcc_pkg;

  // The four enables that steer bus behaviour.
  typedef struct packed {
    logic writeInvalidateEnable;
    logic specialCycleMonitor;
    logic busMasterEnable;
    logic memorySpaceEnable;
  } pcc_enables_t;

endpackage

/* File: include/pcc_ctrl_if.sv */
// Carrier between the command register bank and the transaction gate.
`timescale 1ns/1ps
`default_nettype none

interface pcc_ctrl_if;
  import pcc_pkg::*;

  pcc_enables_t enables;
  logic         busIdle;
  logic         memHit;
  logic         coreMasterReq;
  logic         coreWantsMwi;
  logic         specialCycleSeen;
  logic         memClaim;
  logic         busRequest;
  logic         issueMwi;
  logic         specialCycleTaken;

  // The bank owns the enables and forwards bus events.
  modport bank (
    output enables,
    output busIdle,
    output memHit,
    output coreMasterReq,
    output coreWantsMwi,
    output specialCycleSeen,
    input  memClaim,
    input  busRequest,
    input  issueMwi,
    input  specialCycleTaken
  );

  // The gate applies the enables to bus events.
  modport gate (
    input  enables,
    input  busIdle,
    input  memHit,
    input  coreMasterReq,
    input  coreWantsMwi,
    input  specialCycleSeen,
    output memClaim,
    output busRequest,
    output issueMwi,
    output specialCycleTaken
  );
endinterface

`default_nettype wire

/* File: hdl/pcc_txn_gate.sv */
// Applies latched enables to target claims, master requests and cycles.
`timescale 1ns/1ps
`default_nettype none
`include "pcc_params.svh"

module pcc_txn_gate
  import pcc_pkg::*;
(
  input  wire logic clk,
  input  wire logic resetn,
  pcc_ctrl_if.gate  ctrl
);

  pcc_enables_t effective_r;

  // Enables are only adopted while the bus is idle, so a transaction
  // already under way keeps the enables it started with.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      effective_r <= '0;
    end else if (ctrl.busIdle) begin
      effective_r <= ctrl.enables;
    end
  end

  // Target side: claim a memory hit only when memory space is enabled.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrl.memClaim <= 1'b0;
    end else begin
      ctrl.memClaim <= ctrl.memHit &&
                       effective_r.memorySpaceEnable;
    end
  end

  // Master side: requests and the write-invalidate choice.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrl.busRequest <= 1'b0;
      ctrl.issueMwi   <= 1'b0;
    end else begin
      ctrl.busRequest <= ctrl.coreMasterReq &&
                         effective_r.busMasterEnable;
      // Without the enable a plain memory write is used instead.
      ctrl.issueMwi   <= ctrl.coreMasterReq && ctrl.coreWantsMwi &&
                         effective_r.busMasterEnable &&
                         effective_r.writeInvalidateEnable;
    end
  end

  // Special cycles are passed on only while monitoring is enabled.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrl.specialCycleTaken <= 1'b0;
    end else begin
      ctrl.specialCycleTaken <= ctrl.specialCycleSeen &&
                                effective_r.specialCycleMonitor;
    end
  end

  property p_no_mwi_when_off;
    @(posedge clk) disable iff (!resetn)
    !effective_r.writeInvalidateEnable |=> !ctrl.issueMwi;
  endproperty
  a_no_mwi_when_off: assert property (p_no_mwi_when_off)
    else $error("Write-invalidate issued while disabled.");

  property p_no_master_when_off;
    @(posedge clk) disable iff (!resetn)
    !effective_r.busMasterEnable |=> !ctrl.busRequest;
  endproperty
  a_no_master_when_off: assert property (p_no_master_when_off)
    else $error("Bus requested while mastering is disabled.");

  property p_claim_hit;
    @(posedge clk) disable iff (!resetn)
    ctrl.memHit |=> (ctrl.memClaim == $past(effective_r.memorySpaceEnable));
  endproperty
  a_claim_hit: assert property (p_claim_hit)
    else $error("Memory hit claim does not follow the enable.");

  property p_no_claim_when_off;
    @(posedge clk) disable iff (!resetn)
    !effective_r.memorySpaceEnable |=> !ctrl.memClaim;
  endproperty
  a_no_claim_when_off: assert property (p_no_claim_when_off)
    else $error("Memory access claimed while disabled.");

  property p_sc_ignored;
    @(posedge clk) disable iff (!resetn)
    !effective_r.specialCycleMonitor |=> !ctrl.specialCycleTaken;
  endproperty
  a_sc_ignored: assert property (p_sc_ignored)
    else $error("Special cycle taken while monitoring is off.");

  property p_hold_in_txn;
    @(posedge clk) disable iff (!resetn)
    !ctrl.busIdle |=> $stable(effective_r);
  endproperty
  a_hold_in_txn: assert property (p_hold_in_txn)
    else $error("Enables changed during a transaction.");

endmodule

`default_nettype wire

/* File: hdl/pcc_command_bank.sv */
// Low control bits of the configuration command register and their use.
`timescale 1ns/1ps
`default_nettype none
`include "pcc_params.svh"

module pcc_command_bank
  import pcc_pkg::*;
#(
  // Set when the special-cycle monitor bit may be written.
  parameter bit SPECIAL_CYCLE_WRITABLE = 1'b0
)
(
  input  wire logic                       clk,
  input  wire logic                       resetn,
  input  wire logic                       cfgWrStrobe,
  input  wire logic                       cfgRdStrobe,
  input  wire logic [`PCC_CFG_ADDR_W-1:0] cfgAddr,
  input  wire logic [3:0]                 cfgByteEn,
  input  wire logic [`PCC_CFG_DATA_W-1:0] cfgWrData,
  output logic      [`PCC_CFG_DATA_W-1:0] cfgRdData,
  output logic                            cfgRdValid,
  input  wire logic                       busIdle,
  input  wire logic                       memHit,
  input  wire logic                       coreMasterReq,
  input  wire logic                       coreWantsMwi,
  input  wire logic                       specialCycleSeen,
  output logic                            memClaim,
  output logic                            busRequest,
  output logic                            issueMwi,
  output logic                            specialCycleTaken,
  output logic      [3:0]                 enableView
);

  pcc_ctrl_if ctrl ();

  logic         writeInvalidateEnable_r;
  logic         specialCycleMonitor_r;
  logic         busMasterEnable_r;
  logic         memorySpaceEnable_r;
  logic [`PCC_CMD_W-1:0] cmdView;
  logic         cmdSelected;
  logic         lowLaneWrite;

  // Only the command offset with byte lane 0 reaches the control bits.
  assign cmdSelected  = (cfgAddr == `PCC_CMD_OFFSET);
  assign lowLaneWrite = cfgWrStrobe && cmdSelected && cfgByteEn[0];

  // Read image; reserved and out-of-block bits read as zero.
  always_comb begin
    cmdView = `PCC_CMD_RESET;
    cmdView[`PCC_BIT_WRINV]      = writeInvalidateEnable_r;
    cmdView[`PCC_BIT_SPECIAL]    = specialCycleMonitor_r;
    cmdView[`PCC_BIT_BUS_MASTER] = busMasterEnable_r;
    cmdView[`PCC_BIT_MEM_SPACE]  = memorySpaceEnable_r;
  end

  // Writable enables; everything clears on reset. Reserved bit 0 is not
  // stored, since software keeps it at zero anyway.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      writeInvalidateEnable_r <= 1'b0;
      busMasterEnable_r       <= 1'b0;
      memorySpaceEnable_r     <= 1'b0;
    end else if (lowLaneWrite) begin
      writeInvalidateEnable_r <= cfgWrData[`PCC_BIT_WRINV];
      busMasterEnable_r       <= cfgWrData[`PCC_BIT_BUS_MASTER];
      memorySpaceEnable_r     <= cfgWrData[`PCC_BIT_MEM_SPACE];
    end
  end

  // The monitor bit is read-only zero unless the build allows writing it.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      specialCycleMonitor_r <= 1'b0;
    end else if (lowLaneWrite && SPECIAL_CYCLE_WRITABLE) begin
      specialCycleMonitor_r <= cfgWrData[`PCC_BIT_SPECIAL];
    end
  end

  // Configuration reads answer one cycle after the strobe.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cfgRdData  <= `PCC_ZERO_WORD;
      cfgRdValid <= 1'b0;
    end else begin
      cfgRdValid <= cfgRdStrobe;
      if (cfgRdStrobe && cmdSelected) begin
        cfgRdData <= {16'h0000, cmdView};
      end else if (cfgRdStrobe) begin
        cfgRdData <= `PCC_ZERO_WORD;
      end
    end
  end

  // Registered copy of the enables for observers outside.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      enableView <= 4'h0;
    end else begin
      enableView <= {writeInvalidateEnable_r, specialCycleMonitor_r,
                     busMasterEnable_r, memorySpaceEnable_r};
    end
  end

  // Hand the enables and bus events to the gate.
  // One assignment drives the whole packed word, so it has a single source.
  assign ctrl.enables = '{writeInvalidateEnable: writeInvalidateEnable_r,
                          specialCycleMonitor:   specialCycleMonitor_r,
                          busMasterEnable:       busMasterEnable_r,
                          memorySpaceEnable:     memorySpaceEnable_r};
  assign ctrl.busIdle                       = busIdle;
  assign ctrl.memHit                        = memHit;
  assign ctrl.coreMasterReq                 = coreMasterReq;
  assign ctrl.coreWantsMwi                  = coreWantsMwi;
  assign ctrl.specialCycleSeen              = specialCycleSeen;

  pcc_txn_gate u_gate (
    .clk    (clk),
    .resetn (resetn),
    .ctrl   (ctrl.gate)
  );

  // These come straight from flip-flops inside the gate.
  assign memClaim          = ctrl.memClaim;
  assign busRequest        = ctrl.busRequest;
  assign issueMwi          = ctrl.issueMwi;
  assign specialCycleTaken = ctrl.specialCycleTaken;

  property p_write_invalidate_enable_set;
    @(posedge clk) disable iff (!resetn)
    lowLaneWrite && cfgWrData[`PCC_BIT_WRINV] |=> writeInvalidateEnable_r;
  endproperty
  a_write_invalidate_enable_set: assert property (p_write_invalidate_enable_set)
    else $error("Write-invalidate enable did not set.");

  property p_write_invalidate_enable_clear;
    @(posedge clk) disable iff (!resetn)
    lowLaneWrite && !cfgWrData[`PCC_BIT_WRINV]
      |=> !writeInvalidateEnable_r ##1 !enableView[3];
  endproperty
  a_write_invalidate_enable_clear: assert property (p_write_invalidate_enable_clear)
    else $error("Write-invalidate enable did not clear.");

  property p_bm_write;
    @(posedge clk) disable iff (!resetn)
    lowLaneWrite
      |=> busMasterEnable_r == $past(cfgWrData[`PCC_BIT_BUS_MASTER]);
  endproperty
  a_bm_write: assert property (p_bm_write)
    else $error("Bus master enable does not follow the write.");

  property p_ms_write;
    @(posedge clk) disable iff (!resetn)
    lowLaneWrite
      |=> memorySpaceEnable_r == $past(cfgWrData[`PCC_BIT_MEM_SPACE]);
  endproperty
  a_ms_write: assert property (p_ms_write)
    else $error("Memory space enable does not follow the write.");

  property p_sc_fixed;
    @(posedge clk) disable iff (!resetn)
    !SPECIAL_CYCLE_WRITABLE |-> !specialCycleMonitor_r;
  endproperty
  a_sc_fixed: assert property (p_sc_fixed)
    else $error("Special-cycle monitor set while not writable.");

  property p_other_offset;
    @(posedge clk) disable iff (!resetn)
    cfgWrStrobe && !cmdSelected |=> $stable(cmdView);
  endproperty
  a_other_offset: assert property (p_other_offset)
    else $error("Command bits changed by a write elsewhere.");

  property p_read_back;
    @(posedge clk) disable iff (!resetn)
    cfgRdStrobe && cmdSelected
      |=> cfgRdValid && cfgRdData == {16'h0000, $past(cmdView)};
  endproperty
  a_read_back: assert property (p_read_back)
    else $error("Command read returned the wrong value.");

endmodule

`default_nettype wire

/* File: tb/pcc_host_model.sv */
// Behavioural host that drives memory cycles and special cycles.
`timescale 1ns/1ps
`default_nettype none

module pcc_host_model (
  input  wire logic clk,
  output logic      busIdle,
  output logic      memHit,
  output logic      specialCycleSeen
);
  // The bus starts idle with nothing decoded.
  initial begin
    busIdle          = 1'b1;
    memHit           = 1'b0;
    specialCycleSeen = 1'b0;
  end

  // Called just after a rising edge of clk.
  // Holding the bus busy shows whether enable changes wait for idle.
  task automatic drive(input logic idle, input logic hit, input logic sc);
    busIdle          <= idle;
    memHit           <= hit;
    specialCycleSeen <= sc;
  endtask
endmodule

`default_nettype wire

/* File: tb/pci_command_low_control_bits_bench.sv */
// Self-checking bench for the command register bank.
`timescale 1ns/1ps
`default_nettype none
`include "pcc_params.svh"

module pci_command_low_control_bits_bench;
  import pcc_pkg::*;

  logic        clk;
  logic        resetn;
  logic        cfgWrStrobe;
  logic        cfgRdStrobe;
  logic [7:0]  cfgAddr;
  logic [3:0]  cfgByteEn;
  logic [31:0] cfgWrData;
  logic [31:0] cfgRdData;
  logic        cfgRdValid;
  logic        busIdle;
  logic        memHit;
  logic        coreMasterReq;
  logic        coreWantsMwi;
  logic        specialCycleSeen;
  logic        memClaim;
  logic        busRequest;
  logic        issueMwi;
  logic        specialCycleTaken;
  logic [3:0]  enableView;
  int          badCount;
  int          compares;
  int          cycles;
  logic [15:0] vals [6];
  logic [15:0] e;
  logic [31:0] d;
  logic [3:0]  o;
  logic [3:0]  x;
  logic [3:0]  y;
  logic [31:0] fixedRdData;
  logic [3:0]  fixedView;

  pcc_command_bank #(.SPECIAL_CYCLE_WRITABLE(1'b1)) DUT (
    .clk              (clk),
    .resetn           (resetn),
    .cfgWrStrobe      (cfgWrStrobe),
    .cfgRdStrobe      (cfgRdStrobe),
    .cfgAddr          (cfgAddr),
    .cfgByteEn        (cfgByteEn),
    .cfgWrData        (cfgWrData),
    .cfgRdData        (cfgRdData),
    .cfgRdValid       (cfgRdValid),
    .busIdle          (busIdle),
    .memHit           (memHit),
    .coreMasterReq    (coreMasterReq),
    .coreWantsMwi     (coreWantsMwi),
    .specialCycleSeen (specialCycleSeen),
    .memClaim         (memClaim),
    .busRequest       (busRequest),
    .issueMwi         (issueMwi),
    .specialCycleTaken(specialCycleTaken),
    .enableView       (enableView)
  );

  pcc_host_model host (
    .clk             (clk),
    .busIdle         (busIdle),
    .memHit          (memHit),
    .specialCycleSeen(specialCycleSeen)
  );

  // The default build must keep the special-cycle bit read-only zero.
  pcc_command_bank fixedDut (
    .clk              (clk),
    .resetn           (resetn),
    .cfgWrStrobe      (cfgWrStrobe),
    .cfgRdStrobe      (cfgRdStrobe),
    .cfgAddr          (cfgAddr),
    .cfgByteEn        (cfgByteEn),
    .cfgWrData        (cfgWrData),
    .cfgRdData        (fixedRdData),
    .cfgRdValid       (),
    .busIdle          (busIdle),
    .memHit           (memHit),
    .coreMasterReq    (coreMasterReq),
    .coreWantsMwi     (coreWantsMwi),
    .specialCycleSeen (specialCycleSeen),
    .memClaim         (),
    .busRequest       (),
    .issueMwi         (),
    .specialCycleTaken(),
    .enableView       (fixedView)
  );

  // A 100 ns clock.
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Cuts a hang short; the ceiling is far above the roughly 90 cycles used.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      badCount++;
      end_of_test();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      badCount++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Reserved bits always go out as zero.
  task automatic cfg_write(input logic [7:0] a, input logic [3:0] be,
                           input logic [15:0] v);
    @(posedge clk);
    cfgWrStrobe <= 1'b1;
    cfgAddr     <= a;
    cfgByteEn   <= be;
    cfgWrData   <= {16'h0000, v & 16'h01FE};
    @(posedge clk);
    cfgWrStrobe <= 1'b0;
  endtask

  // The answer must stand exactly one cycle after the strobe is driven.
  task automatic cfg_read(input logic [7:0] a, output logic [31:0] rd);
    @(posedge clk);
    cfgRdStrobe <= 1'b1;
    cfgAddr     <= a;
    @(posedge clk);
    cfgRdStrobe <= 1'b0;
    #1;
    check({31'h0000_0000, cfgRdValid}, 32'h0000_0001);
    rd = cfgRdData;
  endtask

  // Inputs are {special, write-invalidate wish, master wish, memory hit}.
  task automatic bus_run(input logic idle, input logic [3:0] ins,
                         output logic [3:0] outs);
    @(posedge clk);
    host.drive(idle, ins[0], ins[3]);
    coreMasterReq <= ins[1];
    coreWantsMwi  <= ins[2];
    repeat (2) @(posedge clk);
    #1;
    outs = {issueMwi, specialCycleTaken, busRequest, memClaim};
    @(posedge clk);
    host.drive(idle, 1'b0, 1'b0);
    coreMasterReq <= 1'b0;
    coreWantsMwi  <= 1'b0;
  endtask

  task automatic end_of_test;
    if (badCount == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Main sequence: reset state, six enable patterns, refusals, late effect.
  initial begin
    resetn        = 1'b0;
    cfgWrStrobe   = 1'b0;
    cfgRdStrobe   = 1'b0;
    cfgAddr       = 8'h00;
    cfgByteEn     = 4'h0;
    cfgWrData     = 32'h0000_0000;
    coreMasterReq = 1'b0;
    coreWantsMwi  = 1'b0;
    badCount      = 0;
    compares      = 0;
    cycles        = 0;
    vals = '{16'h0002, 16'h0004, 16'h0014, 16'h0010, 16'h0008, 16'h01FE};
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    cfg_read(`PCC_CMD_OFFSET, d);
    check(d, 32'h0000_0000);
    bus_run(1'b1, 4'hF, o);
    check({28'h000_0000, o}, 32'h0000_0000);
    cfg_read(8'h08, d);
    check(d, 32'h0000_0000);
    // Only bits 4 to 1 are stored; upper control bits read zero here.
    foreach (vals[i]) begin
      e = vals[i] & 16'h001E;
      cfg_write(`PCC_CMD_OFFSET, 4'h1, vals[i]);
      cfg_read(`PCC_CMD_OFFSET, d);
      check(d, {16'h0000, e});
      check(fixedRdData, {16'h0000, e & 16'h0016});
      bus_run(1'b1, 4'hF, o);
      // Write-invalidate needs both its own enable and mastering.
      x = {e[4] & e[2], e[3], e[2], e[1]};
      y = {e[4], 1'b0, e[2:1]};
      check({28'h000_0000, o}, {28'h000_0000, x});
      check({28'h000_0000, enableView}, {28'h000_0000, e[4:1]});
      check({28'h000_0000, fixedView}, {28'h000_0000, y});
    end
    // Lane 0 disabled, then a wrong offset: both writes are dropped.
    cfg_write(`PCC_CMD_OFFSET, 4'hE, 16'h0000);
    cfg_write(8'h08, 4'h1, 16'h0000);
    cfg_read(`PCC_CMD_OFFSET, d);
    check(d, 32'h0000_001E);
    // A clear during a busy bus must not cut into the cycle in progress.
    @(posedge clk);
    host.drive(1'b0, 1'b0, 1'b0);
    cfg_write(`PCC_CMD_OFFSET, 4'h1, 16'h0000);
    cfg_read(`PCC_CMD_OFFSET, d);
    check(d, 32'h0000_0000);
    bus_run(1'b0, 4'hF, o);
    check({28'h000_0000, o}, 32'h0000_000F);
    bus_run(1'b1, 4'hF, o);
    check({28'h000_0000, o}, 32'h0000_0000);
    end_of_test();
  end
endmodule

`default_nettype wire
